/* verilog/tw_pkg.sv */
// Constants shared by the trap and wakeup interrupt logic
package tw_pkg;
  localparam int          WAKE_W        = 8;
  localparam int          OPC_W         = 8;
  localparam int          PC_W          = 15;
  localparam int          SP_W          = 8;
  localparam int          VEC_W         = 8;
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 32;
  // Register byte offsets
  localparam logic [4:0]  OFF_CTRL      = 5'h00;
  localparam logic [4:0]  OFF_WAKE_EN   = 5'h04;
  localparam logic [4:0]  OFF_WAKE_EDGE = 5'h08;
  localparam logic [4:0]  OFF_WAKE_PEND = 5'h0C;
  localparam logic [4:0]  OFF_STATUS    = 5'h10;
  // Field positions
  localparam int          CTRL_GIE_BIT  = 0;
  localparam int          CTRL_WAKE_PORT_INT_ENABLE_BIT = 1;
  localparam int          STAT_REQ_BIT  = 0;
  localparam int          STAT_WAKE_BIT = 1;
  // Reset values
  localparam logic [7:0]  WAKE_RST      = 8'h00;
  localparam logic        BIT_RST       = 1'b0;
  // Opcode and address constants
  localparam logic [7:0]  OPC_TRAP      = 8'h00;
  localparam logic [7:0]  STACK_LIMIT   = 8'h6F;
  localparam logic [14:0] PC_TOP        = 15'h7FFF;
  localparam logic [7:0]  VEC_TRAP      = 8'hFE;
  localparam logic [7:0]  VEC_WAKE      = 8'hE2;
  localparam logic [7:0]  VEC_DEFAULT   = 8'hE0;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;
endpackage

/* verilog/tw_intc.sv */
// Trap pending flag, priority, vectoring and wakeup port interrupt logic
// Notes on behaviour
// - Trap flag has no address, unreadable, unwritable
// - Reset clears the trap flag
// - Trap event sets the trap flag
// - Clear-pending instruction clears trap flag, unless a trap event comes in the same cycle
// - Trap opcode loaded into IR raises trap
// - Missing program memory fetches read as zero
// - Pop past stack limit loads top PC
// - Trap outranks all, acknowledged at once
// - Trap keeps GLOBAL_INT_ENABLE, blocks others, selects vector
// - Only another trap preempts a trap routine
// - Trap return address is the opcode address
// - Eight edge wakeup inputs, one vector
// - Per-pin enable gates each wakeup interrupt
// - Per-pin edge select picks rising or falling
// - Per-pin pending latches each trigger
// - Wake request needs port enable and GLOBAL_INT_ENABLE
// - Wake, port disabled: resume after sleep instruction
// - Wake, port enabled: run service routine first
// - Maskable never preempts routine; trap does
// - Return-from-interrupt sets GLOBAL_INT_ENABLE again
// - Vector select gives FE while trap active
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module tw_intc (
  // Clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  // Avalon-MM slave
  input  wire logic [tw_pkg::ADDR_W-1:0]  i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [tw_pkg::DATA_W-1:0]  i_avs_writedata,
  output logic      [tw_pkg::DATA_W-1:0]  o_avs_readdata,
  output logic                            o_avs_waitrequest,
  // Program memory fetch into the instruction register
  input  wire logic                       i_ir_load,
  input  wire logic [tw_pkg::OPC_W-1:0]   i_pmem_data,
  input  wire logic                       i_pmem_exists,
  input  wire logic [tw_pkg::PC_W-1:0]    i_fetch_pc,
  output logic      [tw_pkg::OPC_W-1:0]   o_ir_data,
  output logic                            o_trap,
  output logic      [tw_pkg::PC_W-1:0]    o_ret_addr,
  // Stack pop supervision
  input  wire logic                       i_pop,
  input  wire logic [tw_pkg::SP_W-1:0]    i_sp_next,
  output logic                            o_pc_force,
  output logic      [tw_pkg::PC_W-1:0]    o_pc_force_val,
  // Instruction sequencer
  input  wire logic                       i_clear_nmi_pending_instr,
  input  wire logic                       i_return_from_interrupt_instr,
  input  wire logic                       i_int_ack,
  input  wire logic                       i_vector_select_instr,
  input  wire logic                       i_other_req,
  input  wire logic [tw_pkg::VEC_W-1:0]   i_other_vec,
  output logic                            o_int_req,
  output logic      [tw_pkg::VEC_W-1:0]   o_vec_lo,
  // Wakeup port and low-power control
  input  wire logic [tw_pkg::WAKE_W-1:0]  i_wake_pin,
  input  wire logic                       i_lowpower,
  output logic                            o_wake,
  output logic                            o_wake_to_isr
);
  import tw_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    hit = (a[ADDR_W-1:2] == off[4:2]);
  endfunction

  // Bus handshake: every access answered after one wait cycle
  logic                 ack_r;
  logic [DATA_W-1:0]    rdata_r;
  wire                  bus_req  = i_avs_read | i_avs_write;
  wire                  wr_do    = i_avs_write & ack_r;
  wire                  rd_do    = i_avs_read & ~ack_r;
  wire                  wr_ctrl  = wr_do & hit(i_avs_address, OFF_CTRL);
  wire                  wr_en    = wr_do & hit(i_avs_address, OFF_WAKE_EN);
  wire                  wr_edge  = wr_do & hit(i_avs_address, OFF_WAKE_EDGE);
  wire                  wr_pend  = wr_do & hit(i_avs_address, OFF_WAKE_PEND);

  assign o_avs_waitrequest = bus_req & ~ack_r;
  assign o_avs_readdata    = rdata_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) ack_r <= BIT_RST;
    else       ack_r <= bus_req & ~ack_r;
  end

  // Control state
  logic                 trap_pending_flag_r;
  logic                 global_int_enable_r;
  logic                 wake_port_int_enable_r;
  logic [WAKE_W-1:0]    wake_int_enable_reg_r;
  logic [WAKE_W-1:0]    wake_edge_select_reg_r;
  logic [WAKE_W-1:0]    wake_pending_reg_r;

  // Missing locations fetch as zero, which decodes as the trap opcode
  wire  [OPC_W-1:0]     fetch_word = i_pmem_exists ? i_pmem_data : OPC_TRAP;
  wire                  trap_evt   = i_ir_load & (fetch_word == OPC_TRAP);

  // Trap flag lives only here; no bus path reaches it
  logic trap_pending_flag_nxt;
  assign trap_pending_flag_nxt = trap_evt ? 1'b1 :
                                 i_clear_nmi_pending_instr ? 1'b0 :
                                 trap_pending_flag_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) trap_pending_flag_r <= BIT_RST;
    else       trap_pending_flag_r <= trap_pending_flag_nxt;
  end

  // Fetch path and trap return address
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ir_data  <= OPC_TRAP;
      o_trap     <= BIT_RST;
      o_ret_addr <= '0;
    end else begin
      if (i_ir_load) o_ir_data <= fetch_word;
      o_trap <= trap_evt;
      if (trap_evt) o_ret_addr <= i_fetch_pc;
    end
  end

  // Stack underflow forces the top program address
  wire pop_over = i_pop & (i_sp_next > STACK_LIMIT);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pc_force     <= BIT_RST;
      o_pc_force_val <= PC_TOP;
    end else begin
      o_pc_force     <= pop_over;
      o_pc_force_val <= PC_TOP;
    end
  end

  // Global enable: cleared on entry, set by return; trap leaves it alone
  wire gie_set = i_return_from_interrupt_instr;
  wire gie_clr = i_int_ack & ~trap_evt;
  logic global_int_enable_nxt;
  assign global_int_enable_nxt = gie_set ? 1'b1 :
                                 gie_clr ? 1'b0 :
                                 wr_ctrl ? i_avs_writedata[CTRL_GIE_BIT] :
                                 global_int_enable_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      global_int_enable_r    <= BIT_RST;
      wake_port_int_enable_r <= BIT_RST;
      wake_int_enable_reg_r  <= WAKE_RST;
      wake_edge_select_reg_r <= WAKE_RST;
    end else begin
      global_int_enable_r <= global_int_enable_nxt;
      if (wr_ctrl) wake_port_int_enable_r <= i_avs_writedata[CTRL_WAKE_PORT_INT_ENABLE_BIT];
      if (wr_en)   wake_int_enable_reg_r  <= i_avs_writedata[WAKE_W-1:0];
      if (wr_edge) wake_edge_select_reg_r <= i_avs_writedata[WAKE_W-1:0];
    end
  end

  // Wakeup pins: two-stage sync, then per-pin edge detect
  logic [WAKE_W-1:0] sync1_r;
  logic [WAKE_W-1:0] sync2_r;
  logic [WAKE_W-1:0] prev_r;
  wire  [WAKE_W-1:0] trig;
  wire  [WAKE_W-1:0] wake_pending_nxt;

  // No reset here: the stages track the pins through reset, so an idle-high
  // pin does not look like a rising edge once reset is released
  always_ff @(posedge i_mclk) begin
    sync1_r <= i_wake_pin;
    sync2_r <= sync1_r;
    prev_r  <= sync2_r;
  end

  genvar g;
  generate
    for (g = 0; g < WAKE_W; g++) begin : g_pin
      // Edge select 1 picks falling, 0 picks rising
      assign trig[g] = wake_edge_select_reg_r[g] ? (prev_r[g] & ~sync2_r[g])
                                                 : (~prev_r[g] & sync2_r[g]);
      // Set wins over a write-one clear in the same cycle
      assign wake_pending_nxt[g] = trig[g] |
                                   (wake_pending_reg_r[g] &
                                    ~(wr_pend & i_avs_writedata[g]));
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) wake_pending_reg_r <= WAKE_RST;
    else       wake_pending_reg_r <= wake_pending_nxt;
  end

  // Request and arbitration
  wire wake_any = |(wake_pending_reg_r & wake_int_enable_reg_r);
  wire wake_req = wake_any & wake_port_int_enable_r & global_int_enable_r;
  wire mask_req = (wake_req | (i_other_req & global_int_enable_r));
  // Trap pending blocks every maskable request; GLOBAL_INT_ENABLE low blocks nesting
  assign o_int_req = mask_req & ~trap_pending_flag_r;

  wire [VEC_W-1:0] vec_sel = trap_pending_flag_r ? VEC_TRAP :
                             (i_other_req & global_int_enable_r) ? i_other_vec :
                             wake_req ? VEC_WAKE : VEC_DEFAULT;

  always_ff @(posedge i_mclk) begin
    if (i_rst) o_vec_lo <= VEC_DEFAULT;
    else if (i_vector_select_instr) o_vec_lo <= vec_sel;
  end

  // Wake from HALT or IDLE; with the port interrupt and GLOBAL_INT_ENABLE both on, service first
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wake        <= BIT_RST;
      o_wake_to_isr <= BIT_RST;
    end else begin
      o_wake        <= i_lowpower & wake_any;
      o_wake_to_isr <= i_lowpower & wake_any & wake_req;
    end
  end

  // Read data; unmapped addresses read zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = DATA_ZERO;
    if (hit(i_avs_address, OFF_CTRL)) begin
      rd_mux[CTRL_GIE_BIT]  = global_int_enable_r;
      rd_mux[CTRL_WAKE_PORT_INT_ENABLE_BIT] = wake_port_int_enable_r;
    end else if (hit(i_avs_address, OFF_WAKE_EN)) begin
      rd_mux[WAKE_W-1:0] = wake_int_enable_reg_r;
    end else if (hit(i_avs_address, OFF_WAKE_EDGE)) begin
      rd_mux[WAKE_W-1:0] = wake_edge_select_reg_r;
    end else if (hit(i_avs_address, OFF_WAKE_PEND)) begin
      rd_mux[WAKE_W-1:0] = wake_pending_reg_r;
    end else if (hit(i_avs_address, OFF_STATUS)) begin
      rd_mux[STAT_REQ_BIT]  = o_int_req;
      rd_mux[STAT_WAKE_BIT] = wake_any;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst)      rdata_r <= DATA_ZERO;
    else if (rd_do) rdata_r <= rd_mux;
  end

  // Checks
  a_reset_clears_trap: assert property (@(posedge i_mclk)
    i_rst |=> !trap_pending_flag_r) else $error("trap flag not cleared by reset");
  a_trap_sets_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    trap_evt |=> trap_pending_flag_r) else $error("trap did not set flag");
  a_clear_instr: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_clear_nmi_pending_instr && !trap_evt) |=> !trap_pending_flag_r)
    else $error("clear instruction ignored");
  a_flag_only_cleared: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(trap_pending_flag_r) |-> $past(i_clear_nmi_pending_instr))
    else $error("trap flag cleared by other cause");
  a_zero_fetch_traps: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ir_load && !i_pmem_exists) |=> o_trap && o_ir_data == OPC_TRAP)
    else $error("missing location did not trap");
  a_ret_addr_kept: assert property (@(posedge i_mclk) disable iff (i_rst)
    trap_evt |=> o_ret_addr == $past(i_fetch_pc)) else $error("bad trap return address");
  a_pop_force_pc: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_pop && i_sp_next > STACK_LIMIT) |=> o_pc_force && o_pc_force_val == PC_TOP)
    else $error("stack underflow did not force pc");
  a_trap_blocks_req: assert property (@(posedge i_mclk) disable iff (i_rst)
    trap_pending_flag_r |-> !o_int_req) else $error("request while trap pending");
  a_trap_vector: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_vector_select_instr && trap_pending_flag_r) |=> o_vec_lo == VEC_TRAP)
    else $error("trap vector not selected");
  a_trap_keeps_gie: assert property (@(posedge i_mclk) disable iff (i_rst)
    (trap_evt && !gie_set && !wr_ctrl) |=> global_int_enable_r == $past(global_int_enable_r))
    else $error("trap changed global enable");
  a_return_from_interrupt_instr_sets_gie: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_return_from_interrupt_instr |=> global_int_enable_r) else $error("return left enable low");
  a_wake_needs_gie: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_int_req && !i_other_req) |-> global_int_enable_r && wake_port_int_enable_r)
    else $error("wake request without enables");
  a_pend_sticky: assert property (@(posedge i_mclk) disable iff (i_rst)
    (|wake_pending_reg_r && !wr_pend) |=> (wake_pending_reg_r & $past(wake_pending_reg_r))
    == $past(wake_pending_reg_r)) else $error("wake pending dropped");
  a_trap_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    trap_evt |=> o_trap) else $error("trap not taken at once");
  a_trap_opcode: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ir_load && i_pmem_exists && i_pmem_data == OPC_TRAP)
    |=> o_trap && o_ir_data == OPC_TRAP) else $error("trap opcode did not trap");
  a_no_false_trap: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_ir_load |=> !o_trap) else $error("trap without a fetch");
  a_ret_addr_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !trap_evt |=> $stable(o_ret_addr)) else $error("return address moved without trap");
  a_ack_clears_gie: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_int_ack && !trap_evt && !gie_set) |=> !global_int_enable_r)
    else $error("maskable entry left global enable set");
  a_gie_blocks_req: assert property (@(posedge i_mclk) disable iff (i_rst)
    !global_int_enable_r |-> !o_int_req) else $error("request while global enable low");
  a_vec_held: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_vector_select_instr |=> $stable(o_vec_lo)) else $error("vector moved without select");
  a_pop_no_force: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_pop |=> !o_pc_force) else $error("pc forced without a pop");

  // Wake port checks
  a_rise_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($rose(sync2_r[0]) && !wake_edge_select_reg_r[0]) |=> wake_pending_reg_r[0])
    else $error("rising edge on wake pin 0 not latched");
  a_fall_latches: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($fell(sync2_r[1]) && wake_edge_select_reg_r[1]) |=> wake_pending_reg_r[1])
    else $error("falling edge on wake pin 1 not latched");
  a_rise_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!wake_pending_reg_r[0] && !$rose(sync2_r[0]) && !wake_edge_select_reg_r[0])
    |=> !wake_pending_reg_r[0]) else $error("wake pin 0 latched without rising edge");
  a_pend_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_pend && i_avs_writedata[0] && !trig[0]) |=> !wake_pending_reg_r[0])
    else $error("write-one did not clear wake pending");
  a_en_gates_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wake_int_enable_reg_r == WAKE_RST) |=> !o_wake) else $error("wake with no pin enabled");
  a_en_gates_req: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wake_int_enable_reg_r == WAKE_RST && !i_other_req) |-> !o_int_req)
    else $error("wake request with no pin enabled");
  a_isr_needs_en: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_wake_to_isr |-> o_wake && $past(global_int_enable_r && wake_port_int_enable_r))
    else $error("service wakeup without enables");
  a_isr_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_lowpower && wake_any && wake_req) |=> o_wake_to_isr)
    else $error("enabled port did not wake into service routine");
  a_plain_wake: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_lowpower && !(global_int_enable_r && wake_port_int_enable_r)) |=> !o_wake_to_isr)
    else $error("disabled port sent wakeup to service routine");
  a_no_wake_awake: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_lowpower |=> !o_wake) else $error("wake while not in low power");
  a_wake_vector: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_vector_select_instr && !trap_pending_flag_r && wake_req &&
     !(i_other_req && global_int_enable_r)) |=> o_vec_lo == VEC_WAKE)
    else $error("wake vector not selected");

  // Bus handshake check
  a_bus_wait_one: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($rose(bus_req)) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait");

  c_trap_taken: cover property (@(posedge i_mclk) disable iff (i_rst)
    trap_evt ##[1:20] i_clear_nmi_pending_instr);
  c_trap_over_mask: cover property (@(posedge i_mclk) disable iff (i_rst)
    i_int_ack ##[1:20] trap_evt);
  c_wake_isr: cover property (@(posedge i_mclk) disable iff (i_rst) o_wake_to_isr);
  c_wake_plain: cover property (@(posedge i_mclk) disable iff (i_rst) o_wake && !o_wake_to_isr);
  c_pop_over: cover property (@(posedge i_mclk) disable iff (i_rst) o_pc_force);

endmodule // tw_intc

/* tb/tw_seq_model.sv */
// Instruction sequencer model: vectors on a trap or a maskable request
`timescale 1ns/1ps
module tw_seq_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Requests from the interrupt logic
  input  wire logic i_trap,
  input  wire logic i_int_req,
  // Routine finished, slow answers
  input  wire logic i_done,
  input  wire logic i_slow,
  // Sequencer pulses
  output logic      o_vis,
  output logic      o_ack
);
  logic       busy_r;
  logic       trap_r;
  logic       fired_r;
  logic [1:0] cnt_r;
  always_ff @(posedge i_mclk) begin
    o_vis <= 1'b0;
    o_ack <= 1'b0;
    if (i_rst || i_done) begin
      busy_r  <= 1'b0;
      trap_r  <= 1'b0;
      fired_r <= 1'b0;
      cnt_r   <= 2'h0;
    // A trap preempts any routine, a maskable request only an idle core
    end else if (i_trap || (!busy_r && i_int_req)) begin
      busy_r  <= 1'b1;
      trap_r  <= i_trap;
      fired_r <= 1'b0;
      cnt_r   <= i_slow ? 2'h3 : 2'h0;
    end else if (busy_r && !fired_r) begin
      if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end else begin
        o_vis   <= 1'b1;
        o_ack   <= !trap_r;
        fired_r <= 1'b1;
      end
    end
  end
endmodule // tw_seq_model

/* tb/testbench.sv */
// Self-checking bench for the trap and wakeup interrupt logic
`timescale 1ns/1ps
module testbench;
  import tw_pkg::*;
  logic        i_mclk = 0, i_rst = 1, rd = 0, wr = 0, ir_ld = 0, pm_ex = 1, pop = 0;
  logic        clr = 0, return_from_interrupt_instr = 0, oreq = 0, lowp = 0, slow = 0;
  logic [4:0]  adr = 0;
  logic [31:0] wd = 0, q;
  logic [7:0]  pm = 0, sp = 0, ovec = 0, pins = 8'h02;
  logic [14:0] pc = 0;
  wire  [31:0] rdo;
  wire  [7:0]  ir, vec;
  wire  [14:0] ret, pcv;
  wire         wq, trap, pcf, ireq, wake, w2i, vector_select_instr, ack;
  int          fails = 0, cmp_count = 0;

  tw_intc dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdo), .o_avs_waitrequest(wq),
    .i_ir_load(ir_ld), .i_pmem_data(pm), .i_pmem_exists(pm_ex), .i_fetch_pc(pc),
    .o_ir_data(ir), .o_trap(trap), .o_ret_addr(ret), .i_pop(pop), .i_sp_next(sp),
    .o_pc_force(pcf), .o_pc_force_val(pcv), .i_clear_nmi_pending_instr(clr),
    .i_return_from_interrupt_instr(return_from_interrupt_instr), .i_int_ack(ack), .i_vector_select_instr(vector_select_instr),
    .i_other_req(oreq), .i_other_vec(ovec), .o_int_req(ireq), .o_vec_lo(vec),
    .i_wake_pin(pins), .i_lowpower(lowp), .o_wake(wake), .o_wake_to_isr(w2i));
  tw_seq_model seq_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_trap(trap), .i_int_req(ireq),
    .i_done(clr | return_from_interrupt_instr), .i_slow(slow), .o_vis(vector_select_instr), .o_ack(ack));

  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Avalon access; entered just after a rising edge, read data lands in q
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken as they stood at the rising edge
    do @(posedge i_mclk); while (wq);
    q = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge i_mclk);
  endtask

  task fetch(input logic [7:0] d, input logic e, input logic [14:0] p);
    pm <= d;
    pm_ex <= e;
    pc <= p;
    ir_ld <= 1'b1;
    @(posedge i_mclk);
    ir_ld <= 1'b0;
    @(negedge i_mclk);
  endtask

  task wait_vec(input logic [7:0] e);
    int n;
    n = 0;
    while (vec !== e && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    @(posedge i_mclk);
  endtask

  task pulse_clr;
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    @(negedge i_mclk);
    @(posedge i_mclk);
  endtask

  task t_reset;
    chk(32'(vec), 32'(VEC_DEFAULT));
    chk(32'(pcv), 32'(PC_TOP));
    bus(1'b0, OFF_CTRL, 0);
    chk(q, 0);
    bus(1'b0, 5'h14, 0);
    chk(q, 0);
    bus(1'b0, OFF_WAKE_PEND, 0);
    chk(q, 0);
    $display("reset test done");
  endtask

  task t_trap;
    bus(1'b1, OFF_CTRL, 1);
    fetch(OPC_TRAP, 1'b1, 15'h1234);
    chk(32'(trap), 1);
    chk(32'(ret), 32'h1234);
    wait_vec(VEC_TRAP);
    chk(32'(vec), 32'(VEC_TRAP));
    oreq <= 1'b1;
    ovec <= 8'hFA;
    @(negedge i_mclk);
    chk(32'(ireq), 0);
    @(posedge i_mclk);
    bus(1'b0, OFF_CTRL, 0);
    chk(q, 1);
    fetch(8'h5A, 1'b0, 15'h7FFF);
    chk(32'(ir), 0);
    chk(32'(trap), 1);
    @(posedge i_mclk);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    @(negedge i_mclk);
    chk(32'(ireq), 1);
    wait_vec(8'hFA);
    chk(32'(vec), 32'hFA);
    fetch(OPC_TRAP, 1'b1, 15'h0100);
    wait_vec(VEC_TRAP);
    chk(32'(vec), 32'(VEC_TRAP));
    slow <= 1'b1;
    i_rst <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    bus(1'b1, OFF_CTRL, 1);
    @(negedge i_mclk);
    chk(32'(ireq), 1);
    @(posedge i_mclk);
    oreq <= 1'b0;
    $display("trap test done");
  endtask

  task t_pop(input logic [7:0] s, input logic e);
    pop <= 1'b1;
    sp <= s;
    @(posedge i_mclk);
    pop <= 1'b0;
    @(negedge i_mclk);
    chk(32'(pcf), 32'(e));
    chk(32'(pcv), 32'(PC_TOP));
    @(posedge i_mclk);
    $display("pop test done");
  endtask

  task t_wake;
    pulse_clr;
    bus(1'b1, OFF_CTRL, 0);
    bus(1'b1, OFF_WAKE_EDGE, 2);
    bus(1'b1, OFF_WAKE_PEND, 32'hFF);
    bus(1'b0, OFF_WAKE_PEND, 0);
    chk(q, 0);
    pins <= 8'h01;
    repeat (5) @(posedge i_mclk);
    bus(1'b0, OFF_WAKE_PEND, 0);
    chk(q, 3);
    pins <= 8'h02;
    repeat (5) @(posedge i_mclk);
    bus(1'b0, OFF_WAKE_PEND, 0);
    chk(q, 3);
    bus(1'b1, OFF_WAKE_PEND, 1);
    bus(1'b0, OFF_WAKE_PEND, 0);
    chk(q, 2);
    lowp <= 1'b1;
    repeat (2) @(negedge i_mclk);
    chk(32'(wake), 0);
    @(posedge i_mclk);
    bus(1'b1, OFF_WAKE_EN, 2);
    @(negedge i_mclk);
    chk(32'(wake), 1);
    chk(32'(w2i), 0);
    @(posedge i_mclk);
    bus(1'b1, OFF_CTRL, 2);
    bus(1'b0, OFF_STATUS, 0);
    chk(q, 2);
    bus(1'b1, OFF_CTRL, 3);
    @(negedge i_mclk);
    chk(32'(w2i), 1);
    chk(32'(ireq), 1);
    wait_vec(VEC_WAKE);
    chk(32'(vec), 32'(VEC_WAKE));
    chk(32'(ireq), 0);
    return_from_interrupt_instr <= 1'b1;
    @(posedge i_mclk);
    return_from_interrupt_instr <= 1'b0;
    bus(1'b0, OFF_CTRL, 0);
    chk(q, 3);
    lowp <= 1'b0;
    $display("wake test done");
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset;
    t_trap;
    t_pop(8'h6F, 1'b0);
    t_pop(8'h70, 1'b1);
    t_wake;
    report_and_stop;
  end

  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
endmodule // testbench
